/* File: include/emu_consts.vh */
// Constants for the emulator run and break control block
// How it works
// - Observe target bus at full rate, no waits
// - Normal run halts on any enabled break
// - Counted software break pauses, then resumes
// - Cycle reset mode resets core every interval
// - Trigger pulses low together with core reset
// - Interval expiry resets regardless of core state
// - Cycle reset ignores breaks; only stop ends
// - Parallel entry refused in cycle reset mode
// - Parallel entry keeps the target running
// - Return or trace stop halts trace capture
// - Space entry keeps trace unless trace busy, one command only
// - Stop command in parallel ends the run
// - Host memory access in parallel mode stalls target per unit
// - Stall per access, 16-byte block, 4-byte word
// - Guarded write breaks except in cycle reset mode
// - Address match raises a hardware break
// - Data match raises a hardware break
// - Read/write level match raises a break
// - Delay counts further bus cycles, max 32767
// - Only channel zero offers delay counting
// - Satisfaction count gates the break, max 32767 on channel zero, 4095 on channel one
`ifndef EMU_CONSTS_VH
`define EMU_CONSTS_VH

// Timing
`define CLK_MHZ        200
`define TGT_MHZ        66
`define STALL_TIME_US  3280
`define PAUSE_CYC      20'h00010
`define RST_PULSE_NS   40
`define RST_PULSE_CYC  ((`RST_PULSE_NS * `CLK_MHZ + 999) / 1000)

// Register map: byte addresses, channel select field in bits 7:5, word offsets in bits 3:2
`define A_CMD    8'h00
`define A_STAT   8'h04
`define A_INTV   8'h08
`define A_ACC    8'h0C
`define A_TRC    8'h10
`define A_CH_SEL 3'h1
`define O_ADDR   2'h0
`define O_DATA   2'h1
`define O_CFG    2'h2
`define O_DLY    2'h3

// Command bits, each a one-shot
`define C_GO     0
`define C_CYC    1
`define C_STOP   2
`define C_PRET   3
`define C_PSPC   4
`define C_END    5
`define C_ABORT  6
`define C_DONE   7
`define C_CLRREF 8

// Channel configuration fields
`define F_EN_A   0
`define F_EN_D   1
`define F_EN_RW  2
`define F_RW_LVL 3
`define F_SAT    16
`define SAT_W0   15
`define SAT_W1   12
`define DLY_W    15

// Host access request fields
`define K_SINGLE 2'h0
`define K_DUMP   2'h1
`define K_DIS    2'h2
`define DUMP_RND 17'h0000F
`define DUMP_SH  4
`define DIS_RND  17'h00003
`define DIS_SH   2

`endif

/* File: verilog/break_channel.v */
// One hardware break channel with satisfaction and delay counts
`timescale 1ns/1ps
`include "emu_consts.vh"
module break_channel #(
  parameter HAS_DELAY = 1,
  parameter CNT_W     = 15
)(
  input  wire              ref_clk,
  input  wire              rstn,
  input  wire              arm,
  input  wire              bus_cycle,
  input  wire [31:0]       bus_addr,
  input  wire [31:0]       bus_data,
  input  wire              bus_rw,
  input  wire [31:0]       cmp_addr,
  input  wire [31:0]       cmp_data,
  input  wire [3:0]        cfg,
  input  wire [CNT_W-1:0]  sat_cnt,
  input  wire [`DLY_W-1:0] dly_cnt,
  output reg               hit
);
  reg  [CNT_W-1:0]  seen_r;
  reg  [`DLY_W-1:0] dly_r;
  reg               dly_act_r;
  wire              any_en;
  wire              match;
  wire              sat_done;

  assign any_en = cfg[`F_EN_A] | cfg[`F_EN_D] | cfg[`F_EN_RW];
  assign match  = bus_cycle & any_en
                & (~cfg[`F_EN_A] | (bus_addr == cmp_addr))
                & (~cfg[`F_EN_D] | (bus_data == cmp_data))
                & (~cfg[`F_EN_RW] | (bus_rw == cfg[`F_RW_LVL]));
  // Zero or one in the count means the first match
  assign sat_done = ((seen_r + {{(CNT_W-1){1'b0}}, 1'b1}) >= sat_cnt);

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      seen_r    <= {CNT_W{1'b0}};
      dly_r     <= {`DLY_W{1'b0}};
      dly_act_r <= 1'b0;
      hit       <= 1'b0;
    end else if (arm) begin
      seen_r    <= {CNT_W{1'b0}};
      dly_act_r <= 1'b0;
      hit       <= 1'b0;
    end else begin
      hit <= 1'b0;
      if (dly_act_r) begin
        if (bus_cycle) begin
          if (dly_r <= {{(`DLY_W-1){1'b0}}, 1'b1}) begin
            dly_act_r <= 1'b0;
            hit       <= 1'b1;
          end else begin
            dly_r <= dly_r - {{(`DLY_W-1){1'b0}}, 1'b1};
          end
        end
      end else if (match) begin
        if (sat_done) begin
          seen_r <= {CNT_W{1'b0}};
          if ((HAS_DELAY != 0) && (dly_cnt != {`DLY_W{1'b0}})) begin
            dly_act_r <= 1'b1;
            dly_r     <= dly_cnt;
          end else begin
            hit <= 1'b1;
          end
        end else begin
          seen_r <= seen_r + {{(CNT_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule

/* File: verilog/emu_run_control.v */
// Run, cycle reset, parallel mode and break control of the emulator
`timescale 1ns/1ps
`include "emu_consts.vh"
module emu_run_control #(
  parameter [19:0] STALL_CYC = `STALL_TIME_US * `CLK_MHZ,
  parameter [19:0] PAUSE_CYC = `PAUSE_CYC
)(
  input  wire        ref_clk,
  input  wire        rstn,
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  input  wire        tgt_bus_cycle,
  input  wire [31:0] tgt_addr,
  input  wire [31:0] tgt_data,
  input  wire        tgt_rw,
  input  wire        guard_wr_hit,
  input  wire        sw_break_hit,
  input  wire        sw_pass_hit,
  input  wire        trace_stop_hit,
  output reg         core_run,
  output reg         periodic_core_reset_n,
  output reg         trigger_out_pulse_n,
  output reg         trace_capture_en
);
  localparam [3:0] ST_STOP = 4'h1;
  localparam [3:0] ST_RUN  = 4'h2;
  localparam [3:0] ST_HOLD = 4'h4;
  localparam [3:0] ST_RST  = 4'h8;
  localparam [19:0] RST_CYC = `RST_PULSE_CYC;

  function is_ch;
    input [7:0] a;
    begin
      is_ch = (a[7:5] == `A_CH_SEL);
    end
  endfunction

  function [15:0] units_of;
    input [1:0]  kind;
    input [15:0] len;
    reg   [16:0] s;
    begin
      s = 17'h00000;
      case (kind)
        `K_DUMP: s = ({1'b0, len} + `DUMP_RND) >> `DUMP_SH;
        `K_DIS:  s = ({1'b0, len} + `DIS_RND) >> `DIS_SH;
        default: s = 17'h00001;
      endcase
      units_of = s[15:0];
    end
  endfunction

  reg  [3:0]        state_r;
  reg  [3:0]        state_nxt;
  reg  [19:0]       hold_r;
  reg  [19:0]       hold_nxt;
  reg  [31:0]       intv_r;
  reg  [31:0]       intv_cnt_r;
  reg  [31:0]       intv_nxt;
  reg  [15:0]       units_r;
  reg  [15:0]       units_nxt;
  reg               cyc_r;
  reg               par_r;
  reg               par_nxt;
  reg               spc_r;
  reg               spc_nxt;
  reg               ref_set;
  reg               refused_r;
  reg               trc_busy_r;
  reg  [4:0]        cause_r;
  reg  [31:0]       ch_addr_r [0:1];
  reg  [31:0]       ch_data_r [0:1];
  reg  [3:0]        ch_cfg_r  [0:1];
  reg  [14:0]       ch_sat_r  [0:1];
  reg  [`DLY_W-1:0] ch_dly_r;
  wire [1:0]        ch_hit;
  wire              cmd_wr;
  wire              go_cmd;
  wire              stop_req;
  wire              run_on;
  wire              brk_now;
  wire              enter;
  wire              acc_wr;
  wire              ch_wr;
  wire              ch_sel;
  integer           i;

  assign cmd_wr   = reg_wr && (reg_addr == `A_CMD);
  assign go_cmd   = cmd_wr && reg_wdata[`C_GO] && (state_r == ST_STOP);
  assign stop_req = cmd_wr && (reg_wdata[`C_STOP]
                  || (reg_wdata[`C_ABORT] && par_r));
  assign run_on   = (state_r == ST_RUN) || (state_r == ST_HOLD);
  // Breaks are masked only by cycle reset mode, never by core state
  assign brk_now  = !cyc_r && ((|ch_hit) || guard_wr_hit || sw_break_hit);
  assign enter    = cmd_wr && (reg_wdata[`C_PRET] || reg_wdata[`C_PSPC]);
  assign acc_wr   = reg_wr && (reg_addr == `A_ACC);
  assign ch_wr    = reg_wr && is_ch(reg_addr);
  assign ch_sel   = reg_addr[4];

  // Break channels watch every bus cycle with no stall of the target
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : chan
      localparam integer W = (g == 0) ? `SAT_W0 : `SAT_W1;
      break_channel #(
        .HAS_DELAY (g == 0 ? 1 : 0),
        .CNT_W     (W)
      ) u_chan (
        .ref_clk   (ref_clk),
        .rstn      (rstn),
        .arm       (go_cmd),
        .bus_cycle (tgt_bus_cycle),
        .bus_addr  (tgt_addr),
        .bus_data  (tgt_data),
        .bus_rw    (tgt_rw),
        .cmp_addr  (ch_addr_r[g]),
        .cmp_data  (ch_data_r[g]),
        .cfg       (ch_cfg_r[g]),
        .sat_cnt   (ch_sat_r[g][W-1:0]),
        .dly_cnt   (ch_dly_r),
        .hit       (ch_hit[g])
      );
    end
  endgenerate

  // Run state machine
  always @* begin
    state_nxt = state_r;
    hold_nxt  = hold_r;
    intv_nxt  = intv_cnt_r;
    units_nxt = units_r;
    case (state_r)
      ST_STOP: begin
        if (go_cmd) begin
          state_nxt = ST_RUN;
          intv_nxt  = intv_r;
          units_nxt = 16'h0000;
        end
      end
      ST_RUN: begin
        if (stop_req || brk_now) begin
          state_nxt = ST_STOP;
          units_nxt = 16'h0000;
        end else if (cyc_r && (intv_cnt_r <= 32'h00000001)) begin
          state_nxt = ST_RST;
          hold_nxt  = RST_CYC;
          intv_nxt  = intv_r;
        end else begin
          if (cyc_r) begin
            intv_nxt = intv_cnt_r - 32'h00000001;
          end
          if (sw_pass_hit && !cyc_r) begin
            state_nxt = ST_HOLD;
            hold_nxt  = PAUSE_CYC;
          end else if (units_r != 16'h0000) begin
            state_nxt = ST_HOLD;
            hold_nxt  = STALL_CYC;
            units_nxt = units_r - 16'h0001;
          end
        end
      end
      ST_HOLD, ST_RST: begin
        if (stop_req || brk_now) begin
          state_nxt = ST_STOP;
          units_nxt = 16'h0000;
        end else if (hold_r <= 20'h00001) begin
          state_nxt = ST_RUN;
        end else begin
          hold_nxt = hold_r - 20'h00001;
        end
      end
      default: begin
        state_nxt = ST_STOP;
      end
    endcase
    if (acc_wr && par_r && (state_r != ST_STOP) && (units_r == 16'h0000)) begin
      units_nxt = units_of(reg_wdata[17:16], reg_wdata[15:0]);
    end
  end

  // Parallel mode entry and exit
  always @* begin
    par_nxt = par_r;
    spc_nxt = spc_r;
    ref_set = 1'b0;
    if ((enter || trace_stop_hit) && (state_r != ST_STOP) && !par_r) begin
      if (cyc_r) begin
        ref_set = 1'b1;
      end else begin
        par_nxt = 1'b1;
        spc_nxt = enter && reg_wdata[`C_PSPC] && !reg_wdata[`C_PRET] && !trace_stop_hit;
      end
    end
    if (par_r && cmd_wr && (reg_wdata[`C_END] || (reg_wdata[`C_DONE] && spc_r))) begin
      par_nxt = 1'b0;
    end
    if (state_nxt == ST_STOP) begin
      par_nxt = 1'b0;
    end
  end

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_r               <= ST_STOP;
      hold_r                <= 20'h00000;
      intv_cnt_r            <= 32'h00000000;
      units_r               <= 16'h0000;
      cyc_r                 <= 1'b0;
      par_r                 <= 1'b0;
      spc_r                 <= 1'b0;
      refused_r             <= 1'b0;
      cause_r               <= 5'h00;
      core_run              <= 1'b0;
      periodic_core_reset_n <= 1'b1;
      trigger_out_pulse_n   <= 1'b1;
      trace_capture_en      <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      hold_r     <= hold_nxt;
      intv_cnt_r <= intv_nxt;
      units_r    <= units_nxt;
      par_r      <= par_nxt;
      spc_r      <= spc_nxt;
      if (go_cmd) begin
        cyc_r <= reg_wdata[`C_CYC];
      end
      // A refusal in the clearing cycle still sticks
      refused_r <= ref_set || (refused_r && !(cmd_wr && reg_wdata[`C_CLRREF]));
      if (go_cmd) begin
        cause_r <= 5'h00;
      end else if ((run_on || state_r == ST_RST) && stop_req) begin
        cause_r <= {1'b1, cause_r[3:0]};
      end else if (run_on && brk_now) begin
        cause_r <= cause_r | {1'b0, sw_break_hit, guard_wr_hit, ch_hit};
      end
      core_run              <= (state_nxt == ST_RUN);
      periodic_core_reset_n <= (state_nxt != ST_RST);
      trigger_out_pulse_n   <= (state_nxt != ST_RST);
      trace_capture_en      <= (state_nxt != ST_STOP)
                             && !(par_nxt && !spc_nxt)
                             && !(par_nxt && spc_nxt && trc_busy_r);
    end
  end

  // Configuration registers
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      intv_r     <= 32'h00000000;
      trc_busy_r <= 1'b0;
      ch_dly_r   <= {`DLY_W{1'b0}};
      for (i = 0; i < 2; i = i + 1) begin
        ch_addr_r[i] <= 32'h00000000;
        ch_data_r[i] <= 32'h00000000;
        ch_cfg_r[i]  <= 4'h0;
        ch_sat_r[i]  <= 15'h0000;
      end
    end else begin
      if (reg_wr && (reg_addr == `A_INTV)) begin
        intv_r <= reg_wdata;
      end
      if (reg_wr && (reg_addr == `A_TRC)) begin
        trc_busy_r <= reg_wdata[0];
      end
      if (ch_wr) begin
        case (reg_addr[3:2])
          `O_ADDR: ch_addr_r[ch_sel] <= reg_wdata;
          `O_DATA: ch_data_r[ch_sel] <= reg_wdata;
          `O_CFG: begin
            ch_cfg_r[ch_sel] <= reg_wdata[3:0];
            if (ch_sel) begin
              ch_sat_r[1] <= {3'b000, reg_wdata[`F_SAT+`SAT_W1-1:`F_SAT]};
            end else begin
              ch_sat_r[0] <= reg_wdata[`F_SAT+`SAT_W0-1:`F_SAT];
            end
          end
          default: begin
            if (!ch_sel) begin
              ch_dly_r <= reg_wdata[`DLY_W-1:0];
            end
          end
        endcase
      end
    end
  end

  // Read port, data valid only in the cycle after the strobe
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      if (is_ch(reg_addr)) begin
        case (reg_addr[3:2])
          `O_ADDR: reg_rdata <= ch_addr_r[ch_sel];
          `O_DATA: reg_rdata <= ch_data_r[ch_sel];
          `O_CFG:  reg_rdata <= {1'b0, ch_sat_r[ch_sel], 12'h000, ch_cfg_r[ch_sel]};
          default: reg_rdata <= ch_sel ? 32'h00000000 : {17'h00000, ch_dly_r};
        endcase
      end else begin
        case (reg_addr)
          `A_STAT: reg_rdata <= {12'h000, state_r, 3'b000, cause_r,
                                 3'b000, refused_r, trace_capture_en,
                                 spc_r, par_r, cyc_r};
          `A_INTV: reg_rdata <= intv_r;
          `A_ACC:  reg_rdata <= {16'h0000, units_r};
          `A_TRC:  reg_rdata <= {31'h00000000, trc_busy_r};
          default: reg_rdata <= 32'h00000000;
        endcase
      end
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end
endmodule

/* File: testbench/run_ctl_checker.sv */
// Port assertions for the emulator run control block
`timescale 1ns/1ps
module run_ctl_checker #(
  parameter [19:0] PAUSE_CYC = 20'h00010
)(
  input wire        ref_clk,
  input wire        rstn,
  input wire [7:0]  reg_addr,
  input wire [31:0] reg_wdata,
  input wire        reg_wr,
  input wire        guard_wr_hit,
  input wire        sw_break_hit,
  input wire        sw_pass_hit,
  input wire        core_run,
  input wire        periodic_core_reset_n,
  input wire        trigger_out_pulse_n,
  input wire        trace_capture_en
);
  localparam int PW = PAUSE_CYC;
  reg  cyc_r;
  wire cmd_wr = reg_wr && (reg_addr == 8'h00);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // Cycle reset mode as commanded by the host
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn)
      cyc_r <= 1'b0;
    else if (cmd_wr && reg_wdata[2])
      cyc_r <= 1'b0;
    else if (cmd_wr && reg_wdata[1:0] == 2'h3 && !core_run)
      cyc_r <= 1'b1;
  end
  a_trigger_out_pulse_with_reset: assert property (
    trigger_out_pulse_n == periodic_core_reset_n) else $error("trigger apart from reset");
  a_reset_width: assert property (
    $fell(periodic_core_reset_n) |-> !periodic_core_reset_n [*8] ##1 periodic_core_reset_n)
    else $error("core reset width wrong");
  a_run_in_reset: assert property (
    !periodic_core_reset_n |-> !core_run) else $error("core runs in reset");
  a_guard_break: assert property (
    guard_wr_hit && core_run && !cyc_r |=> !core_run) else $error("guard write no stop");
  a_sw_break: assert property (
    sw_break_hit && core_run && !cyc_r |=> !core_run) else $error("sw break no stop");
  a_cyc_no_break: assert property (
    (guard_wr_hit || sw_break_hit) && cyc_r && core_run |=> core_run || !periodic_core_reset_n)
    else $error("break honoured in cycle mode");
  a_pause_resume: assert property (
    sw_pass_hit && core_run && !cyc_r |=> !core_run ##PW core_run) else $error("pause wrong");
  a_return_trace: assert property (
    cmd_wr && reg_wdata[3] && core_run && !cyc_r |-> ##2 !trace_capture_en)
    else $error("trace still on");
  a_par_keeps_run: assert property (
    cmd_wr && (reg_wdata == 32'h8 || reg_wdata == 32'h10) && core_run && !cyc_r
    |=> core_run [*2]) else $error("parallel entry halted core");
endmodule

/* File: testbench/tgt_model.sv */
// Target core model issuing one bus cycle per running clock
`timescale 1ns/1ps
module tgt_model (
  input  wire        ref_clk,
  input  wire        rstn,
  input  wire        core_run,
  input  wire        core_rst_n,
  output reg         bus_cycle,
  output reg  [31:0] addr,
  output reg  [31:0] data,
  output reg         rw
);
  reg [31:0] pc_r;
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pc_r      <= 32'h1000;
      bus_cycle <= 1'b0;
      addr      <= 32'h0;
      data      <= 32'h0;
      rw        <= 1'b0;
    end else if (core_run && core_rst_n) begin
      bus_cycle <= 1'b1;
      addr      <= pc_r;
      data      <= {pc_r[15:0], ~pc_r[15:0]};
      rw        <= pc_r[2];
      pc_r      <= pc_r + 32'h4;
    end else begin
      // Idle bus shows no stale value
      bus_cycle <= 1'b0;
      addr      <= ~addr;
      data      <= ~data;
      rw        <= ~rw;
      if (!core_rst_n)
        pc_r <= 32'h1000;
    end
  end
endmodule

/* File: testbench/testbench.sv */
// Self-checking bench for the emulator run control block
`timescale 1ns/1ps
`include "emu_consts.vh"
module testbench;
  reg         ref_clk;
  reg         rstn;
  reg  [7:0]  reg_addr;
  reg  [31:0] reg_wdata;
  reg         reg_wr;
  reg         reg_rd;
  reg         guard_wr_hit;
  reg         sw_break_hit;
  reg         sw_pass_hit;
  reg         trace_stop_hit;
  wire [31:0] reg_rdata;
  wire        tgt_bus_cycle;
  wire [31:0] tgt_addr;
  wire [31:0] tgt_data;
  wire        tgt_rw;
  wire        core_run;
  wire        periodic_core_reset_n;
  wire        trigger_out_pulse_n;
  wire        trace_capture_en;
  integer     error_cnt;
  integer     comparisons;
  integer     cyc;
  integer     n;
  integer     k;
  integer     lo;
  reg  [31:0] rv;
  reg  [31:0] tgt;
  reg  [31:0] gap;
  reg  [31:0] n0;

  emu_run_control #(.STALL_CYC(20'h00014), .PAUSE_CYC(20'h00004)) emu_run_control_inst (
    .ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .tgt_bus_cycle(tgt_bus_cycle), .tgt_addr(tgt_addr), .tgt_data(tgt_data),
    .tgt_rw(tgt_rw), .guard_wr_hit(guard_wr_hit), .sw_break_hit(sw_break_hit),
    .sw_pass_hit(sw_pass_hit), .trace_stop_hit(trace_stop_hit), .core_run(core_run),
    .periodic_core_reset_n(periodic_core_reset_n),
    .trigger_out_pulse_n(trigger_out_pulse_n), .trace_capture_en(trace_capture_en));

  tgt_model tgt_model_inst (
    .ref_clk(ref_clk), .rstn(rstn), .core_run(core_run),
    .core_rst_n(periodic_core_reset_n), .bus_cycle(tgt_bus_cycle),
    .addr(tgt_addr), .data(tgt_data), .rw(tgt_rw));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task end_sim;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask

  task chk(input [31:0] seen, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        error_cnt = error_cnt + 1;
        $display("mismatch at %0t: got %h want %h", $time, seen, exp);
      end
    end
  endtask

  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge ref_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge ref_clk);
      reg_wr    <= 1'b0;
    end
  endtask

  task rd(input [7:0] a);
    begin
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge ref_clk);
      reg_rd   <= 1'b0;
      #1;
      rv = reg_rdata;
    end
  endtask

  // Bits: trace stop, pass, sw break, guard
  task hit(input [3:0] m);
    begin
      @(posedge ref_clk);
      {trace_stop_hit, sw_pass_hit, sw_break_hit, guard_wr_hit} <= m;
      @(posedge ref_clk);
      {trace_stop_hit, sw_pass_hit, sw_break_hit, guard_wr_hit} <= 4'h0;
    end
  endtask

  task stop_cause(input [4:0] c);
    begin
      #1;
      n = 0;
      while (core_run !== 1'b0 && n < 500) begin
        @(posedge ref_clk);
        #1;
        n = n + 1;
      end
      rd(`A_STAT);
      chk({rv[19:16], rv[12:8]}, {4'h1, c});
    end
  endtask

  // Edges from now until the next core reset fall
  task wfall;
    begin
      n = 0;
      while (periodic_core_reset_n !== 1'b1 && n < 300) begin
        @(posedge ref_clk);
        #1;
        n = n + 1;
      end
      while (periodic_core_reset_n !== 1'b0 && n < 300) begin
        @(posedge ref_clk);
        #1;
        n = n + 1;
      end
    end
  endtask

  task t_reset;
    begin
      chk({core_run, periodic_core_reset_n, trigger_out_pulse_n, trace_capture_en}, 4'h6);
      rd(`A_STAT);
      chk(rv, 32'h10000);
      rd(8'h44);
      chk(rv, 32'h0);
      wr(`A_INTV, 32'h1234);
      rd(`A_INTV);
      chk(rv, 32'h1234);
      $display("t_reset done");
    end
  endtask

  task t_break(input [7:0] ch, input [31:0] cfg, input [4:0] c, input [14:0] dly);
    begin
      tgt = tgt_model_inst.pc_r + 32'h28;
      wr(ch, tgt);
      wr(ch + 8'h04, {tgt[15:0], ~tgt[15:0]});
      wr(ch + 8'h08, cfg | {28'h0, tgt[2], 3'h0});
      wr(ch + 8'h0C, {17'h0, dly});
      wr(`A_CMD, 32'h1);
      stop_cause(c);
      gap = tgt_model_inst.pc_r - tgt;
      wr(ch + 8'h08, 32'h0);
      $display("t_break done");
    end
  endtask

  task t_hits;
    begin
      wr(`A_CMD, 32'h1);
      hit(4'h4);
      repeat (8) @(posedge ref_clk);
      #1;
      chk(core_run, 1'b1);
      hit(4'h1);
      stop_cause(5'h04);
      wr(`A_CMD, 32'h1);
      hit(4'h2);
      stop_cause(5'h08);
      $display("t_hits done");
    end
  endtask

  task t_cycle;
    begin
      wr(`A_INTV, 32'h5);
      wr(`A_CMD, 32'h3);
      wfall;
      wfall;
      chk(n, `RST_PULSE_CYC + 32'h5);
      wr(`A_CMD, 32'h8);
      rd(`A_STAT);
      chk({rv[4], rv[1]}, 2'h2);
      wfall;
      wfall;
      chk(n, `RST_PULSE_CYC + 32'h5);
      repeat (9) @(posedge ref_clk);
      // Breaks land while the core runs between resets
      hit(4'h3);
      #1;
      chk(core_run, 1'b1);
      wr(`A_CMD, 32'h4);
      stop_cause(5'h10);
      wr(`A_CMD, 32'h100);
      rd(`A_STAT);
      chk(rv[4], 1'b0);
      $display("t_cycle done");
    end
  endtask

  task t_par;
    begin
      wr(`A_CMD, 32'h1);
      wr(`A_CMD, 32'h8);
      rd(`A_STAT);
      chk({core_run, rv[3:0]}, 5'h12);
      wr(`A_CMD, 32'h20);
      rd(`A_STAT);
      chk(rv[3:0], 4'h8);
      wr(`A_CMD, 32'h10);
      rd(`A_STAT);
      chk(rv[3:0], 4'hE);
      wr(`A_TRC, 32'h1);
      @(posedge ref_clk);
      #1;
      chk(trace_capture_en, 1'b0);
      wr(`A_TRC, 32'h0);
      wr(`A_CMD, 32'h80);
      rd(`A_STAT);
      chk(rv[3:0], 4'hC);
      hit(4'h8);
      @(posedge ref_clk);
      #1;
      chk(trace_capture_en, 1'b0);
      for (k = 0; k < 3; k = k + 1) begin
        wr(`A_ACC, (k == 0) ? 32'h4 : (k == 1) ? 32'h10011 : 32'h20009);
        lo = 0;
        repeat (120) begin
          @(posedge ref_clk);
          #1;
          if (core_run === 1'b0)
            lo = lo + 1;
        end
        chk(lo, (k + 1) * 20);
      end
      wr(`A_CMD, 32'h40);
      stop_cause(5'h10);
      rd(`A_STAT);
      chk({rv[19:16], rv[1]}, 5'h02);
      $display("t_par done");
    end
  endtask

  initial begin
    error_cnt = 0;
    comparisons = 0;
    cyc = 0;
    rstn = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    {trace_stop_hit, sw_pass_hit, sw_break_hit, guard_wr_hit} = 4'h0;
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
    t_reset;
    t_break(8'h20, 32'h1, 5'h01, 15'h0000);
    n0 = gap;
    chk(n0 < 32'h10, 1'b1);
    t_break(8'h30, 32'h6, 5'h02, 15'h0000);
    chk(gap, n0);
    t_break(8'h20, 32'h1, 5'h01, 15'h0003);
    chk(gap, n0 + 32'hC);
    wr(8'h3C, 32'h5);
    rd(8'h3C);
    chk(rv, 32'h0);
    t_hits;
    t_cycle;
    t_par;
    end_sim;
  end

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt = error_cnt + 1;
      end_sim;
    end
  end
endmodule

bind emu_run_control run_ctl_checker #(.PAUSE_CYC(PAUSE_CYC)) run_ctl_checker_inst (
  .ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .guard_wr_hit(guard_wr_hit), .sw_break_hit(sw_break_hit),
  .sw_pass_hit(sw_pass_hit), .core_run(core_run),
  .periodic_core_reset_n(periodic_core_reset_n),
  .trigger_out_pulse_n(trigger_out_pulse_n), .trace_capture_en(trace_capture_en));
